// ### verilog/fpau_defs.svh
`ifndef FPAU_DEFS_SVH
`define FPAU_DEFS_SVH

// register bus byte offsets
`define FPAU_OFS_GPR0       8'h00
`define FPAU_OFS_STATUS     8'h20
`define FPAU_GPR_SPAN_HI    3'h0
`define FPAU_STAT_BUSY_BIT  8

// reset values
`define FPAU_CC_RESET       4'h0
`define FPAU_GPR_RESET      32'h0000_0000

// condition code bit positions (bit 3 is the first, leftmost bit)
`define FPAU_CC_EXC         3
`define FPAU_CC_POS         2
`define FPAU_CC_NEG         1
`define FPAU_CC_ZERO        0

// instruction fields; instruction bit n sits at vector bit 31-n
`define FPAU_OPC_HI         31
`define FPAU_OPC_LO         26
`define FPAU_RD_HI          25
`define FPAU_RD_LO          23
`define FPAU_RS_HI          22
`define FPAU_RS_LO          20
`define FPAU_AUG_HI         19
`define FPAU_AUG_LO         16
`define FPAU_X_HI           22
`define FPAU_X_LO           21
`define FPAU_IND_BIT        20
`define FPAU_F_BIT          19
`define FPAU_ADDR_HI        19
`define FPAU_ADDR_LO        0
`define FPAU_C_HI           1
`define FPAU_C_LO           0

// operation codes
`define FPAU_OP_ADD_MEM     6'h2e
`define FPAU_OP_REG_REG     6'h0e
`define FPAU_AUG_ADD        4'h0
`define FPAU_C_WORD         2'h0
`define FPAU_C_DOUBLE       2'h2

// operand extension
`define FPAU_BYTE_ZEROS     24
`define FPAU_HALF_SIGN      15

`endif

// ### verilog/fpau_pkg.sv
`default_nettype none
package fpau_pkg;

	typedef enum logic [2:0] {
		FPAU_S_IDLE   = 3'b000,
		FPAU_S_RD_LO  = 3'b001,
		FPAU_S_CAP_LO = 3'b010,
		FPAU_S_RD_HI  = 3'b011,
		FPAU_S_CAP_HI = 3'b100,
		FPAU_S_WR_LO  = 3'b101,
		FPAU_S_WR_HI  = 3'b110
	} fpau_state_e_t;

	typedef enum logic [2:0] {
		FPAU_K_BYTE   = 3'b000,
		FPAU_K_HALF   = 3'b001,
		FPAU_K_WORD   = 3'b010,
		FPAU_K_DOUBLE = 3'b011,
		FPAU_K_REGREG = 3'b100
	} fpau_kind_e_t;

	typedef struct packed {
		fpau_state_e_t st;
		fpau_kind_e_t  kind;
		logic [2:0]    reg_r;
		logic [2:0]    reg_s;
		logic [31:0]   op_hi;
		logic [31:0]   op_lo;
		logic [31:0]   sum_lo;
		logic [31:0]   sum_hi;
		logic          carry;
		logic [3:0]    cc;
		logic          busy;
		logic          done;
		logic          illegal;
		logic [19:0]   oper_addr;
		logic          addr_direct;
		logic [31:0]   misc_rdata;
		logic          rd_gpr;
	} fpau_top_state_t;

endpackage
`default_nettype wire

// ### verilog/fpau_rf_if.sv
`default_nettype none
interface fpau_rf_if #(
	parameter int WIDTH = 32,
	parameter int AW    = 3
);
	logic             rd_en;
	logic [AW-1:0]    rd_addr;
	logic [WIDTH-1:0] rd_data;
	logic             wr_en;
	logic [AW-1:0]    wr_addr;
	logic [WIDTH-1:0] wr_data;

	modport ctrl (
		output rd_en,
		output rd_addr,
		input  rd_data,
		output wr_en,
		output wr_addr,
		output wr_data
	);

	modport mem (
		input  rd_en,
		input  rd_addr,
		output rd_data,
		input  wr_en,
		input  wr_addr,
		input  wr_data
	);
endinterface
`default_nettype wire

// ### verilog/fpau_regfile.sv
`default_nettype none
`include "fpau_defs.svh"
module fpau_regfile #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	fpau_rf_if.mem    rf
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd_data;
	} fpau_rf_state_t;

	fpau_rf_state_t q;
	fpau_rf_state_t d;

	if (DEPTH != (1 << AW))
	begin : g_bad_depth
		$error("fpau_regfile: DEPTH must equal 2**AW");
	end

	// read returns the old word when read and write hit the same entry
	always_comb
	begin
		d = q;
		if (rf.rd_en)
		begin
			d.rd_data = q.mem[rf.rd_addr];
		end
		if (rf.wr_en)
		begin
			d.mem[rf.wr_addr] = rf.wr_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			q <= '0;
		end
		else if (i_ce)
		begin
			q <= d;
		end
	end

	assign rf.rd_data = q.rd_data;
endmodule // fpau_regfile
`default_nettype wire

// ### verilog/fpau_top.sv
// Overview of operation
// - register-to-register adds take the destination from bits 6-8 and the source from bits 9-11.
// - the opcode comes from bits 0-5 and, for register-to-register, the augmenting code from bits 12-15.
// - after an add the condition code shows greater, less or equal to zero and flags exceptions.
// - a four-bit condition code register is kept and forms the condition code part of the status word.
// - every operation the unit performs updates the condition code.
// - one binary adder serves signed and unsigned data; the flags read the result as two's complement.
// - byte, halfword, word and doubleword operands are supported.
// - a byte operand gets 24 zero bits on top, is added to register R and the sum goes back to R.
// - for byte, halfword and word adds the flags are exception, positive, negative and zero of the word.
// - a halfword operand has its sign bit copied into the upper 16 bits before the add into R.
// - a word operand is added whole to register R and the sum replaces R.
// - a doubleword add first adds R+1 to the low word, then R plus the carry to the high word.
// - the doubleword result goes to R (high) and R+1 (low), R+1 being the next register up, or register 0 when R is 7.
// - doubleword sign and zero flags are judged on the 64-bit pair, the first bit on exception.
// - the operand address is bits 12-31 when the index and indirect fields are both zero.
`default_nettype none
`include "fpau_defs.svh"
module fpau_top #(
	parameter int DATA_W   = 32,
	parameter int NUM_REGS = 8
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic        i_start,
	input  wire logic [31:0] i_instr,
	input  wire logic [31:0] i_operand_hi,
	input  wire logic [31:0] i_operand_lo,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	output logic      [3:0]  o_cond_code,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_illegal,
	output logic      [19:0] o_operand_addr,
	output logic             o_addr_direct
);
	fpau_pkg::fpau_top_state_t q;
	fpau_pkg::fpau_top_state_t d;

	fpau_rf_if #(.WIDTH(32), .AW(3)) rf ();

	fpau_regfile #(
		.WIDTH (32),
		.DEPTH (8),
		.AW    (3)
	) u_regfile (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.rf        (rf.mem)
	);

	if (DATA_W != 32)
	begin : g_bad_width
		$error("fpau_top: only a 32-bit datapath is supported");
	end
	if (NUM_REGS != 8)
	begin : g_bad_regs
		$error("fpau_top: register number fields are three bits wide");
	end

	logic        bus_gpr_hit;
	logic        bus_gpr_rd;
	logic        bus_gpr_wr;
	logic        bus_stat_hit;
	logic [5:0]  dec_opc;
	logic [3:0]  dec_aug;
	logic [1:0]  dec_c;
	logic [31:0] ext_byte;
	logic [31:0] ext_half;
	logic [31:0] add_a;
	logic [31:0] add_b;
	logic        add_cin;
	logic [32:0] sum33;
	logic [32:0] lo33;
	logic [31:0] res;
	logic        ovf;
	logic        res_neg;
	logic        res_zero;
	logic        fsm_rd_en;
	logic [2:0]  fsm_rd_addr;
	logic        fsm_wr_en;
	logic [2:0]  fsm_wr_addr;
	logic [31:0] fsm_wr_data;

	always_comb
	begin
		bus_gpr_hit  = (i_reg_addr[7:5] == `FPAU_GPR_SPAN_HI)
			&& (i_reg_addr[1:0] == 2'h0);
		bus_stat_hit = (i_reg_addr == `FPAU_OFS_STATUS);
		bus_gpr_rd   = i_reg_rd && bus_gpr_hit;
		bus_gpr_wr   = i_reg_wr && bus_gpr_hit;
		dec_opc      = i_instr[`FPAU_OPC_HI:`FPAU_OPC_LO];
		dec_aug      = i_instr[`FPAU_AUG_HI:`FPAU_AUG_LO];
		dec_c        = i_instr[`FPAU_C_HI:`FPAU_C_LO];
		ext_byte     = {{`FPAU_BYTE_ZEROS{1'b0}}, i_operand_lo[7:0]};
		ext_half     = {{16{i_operand_lo[`FPAU_HALF_SIGN]}},
			i_operand_lo[15:0]};
	end

	// the bus owns the register file ports when it asks; the sequence
	// simply holds its state one cycle, so software is never stalled
	always_comb
	begin
		fsm_rd_en   = 1'b0;
		fsm_rd_addr = q.reg_r;
		fsm_wr_en   = 1'b0;
		fsm_wr_addr = q.reg_r;
		fsm_wr_data = q.sum_hi;
		case (q.st)
			fpau_pkg::FPAU_S_RD_LO:
			begin
				fsm_rd_en = 1'b1;
				if (q.kind == fpau_pkg::FPAU_K_REGREG)
				begin
					fsm_rd_addr = q.reg_s;
				end
				else
				begin
					fsm_rd_addr = 3'(q.reg_r + 3'h1);
				end
			end
			fpau_pkg::FPAU_S_RD_HI:
			begin
				fsm_rd_en   = 1'b1;
				fsm_rd_addr = q.reg_r;
			end
			fpau_pkg::FPAU_S_WR_LO:
			begin
				fsm_wr_en   = 1'b1;
				fsm_wr_addr = 3'(q.reg_r + 3'h1);
				fsm_wr_data = q.sum_lo;
			end
			fpau_pkg::FPAU_S_WR_HI:
			begin
				fsm_wr_en = 1'b1;
			end
			default:
			begin
				fsm_rd_en = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		rf.rd_en   = bus_gpr_rd || fsm_rd_en;
		rf.rd_addr = bus_gpr_rd ? i_reg_addr[4:2] : fsm_rd_addr;
		rf.wr_en   = bus_gpr_wr || fsm_wr_en;
		rf.wr_addr = bus_gpr_wr ? i_reg_addr[4:2] : fsm_wr_addr;
		rf.wr_data = bus_gpr_wr ? i_reg_wdata : fsm_wr_data;
	end

	// one adder for every size and sign but the low word of a double,
	// which lo33 adds; the high word takes the low-word carry in
	always_comb
	begin
		add_a = rf.rd_data;
		if (q.kind == fpau_pkg::FPAU_K_DOUBLE)
		begin
			add_b   = q.op_hi;
			add_cin = q.carry;
		end
		else
		begin
			add_b   = q.op_lo;
			add_cin = 1'b0;
		end
		sum33    = {1'b0, add_a} + {1'b0, add_b} + {32'h0, add_cin};
		lo33     = {1'b0, rf.rd_data} + {1'b0, q.op_lo};
		res      = sum33[31:0];
		ovf      = (add_a[31] == add_b[31]) && (res[31] != add_a[31]);
		res_neg  = res[31];
		if (q.kind == fpau_pkg::FPAU_K_DOUBLE)
		begin
			res_zero = (res == 32'h0) && (q.sum_lo == 32'h0);
		end
		else
		begin
			res_zero = (res == 32'h0);
		end
	end

	always_comb
	begin
		d         = q;
		d.done    = 1'b0;
		d.rd_gpr  = bus_gpr_rd;
		if (i_reg_rd)
		begin
			d.misc_rdata = 32'h0;
			if (bus_stat_hit)
			begin
				d.misc_rdata[3:0] = q.cc;
				d.misc_rdata[`FPAU_STAT_BUSY_BIT] = q.busy;
			end
		end
		if (i_reg_wr && bus_stat_hit)
		begin
			d.cc = i_reg_wdata[3:0];
		end
		case (q.st)
			fpau_pkg::FPAU_S_IDLE:
			begin
				if (i_start)
				begin
					d.illegal = 1'b0;
					d.carry   = 1'b0;
					d.reg_r   = i_instr[`FPAU_RD_HI:`FPAU_RD_LO];
					d.reg_s   = i_instr[`FPAU_RS_HI:`FPAU_RS_LO];
					d.oper_addr = i_instr[`FPAU_ADDR_HI:`FPAU_ADDR_LO];
					d.addr_direct = (i_instr[`FPAU_X_HI:`FPAU_X_LO] == 2'h0)
						&& !i_instr[`FPAU_IND_BIT];
					d.op_hi = i_operand_hi;
					d.op_lo = i_operand_lo;
					if (dec_opc == `FPAU_OP_ADD_MEM)
					begin
						d.busy = 1'b1;
						d.st   = fpau_pkg::FPAU_S_RD_HI;
						if (i_instr[`FPAU_F_BIT])
						begin
							d.kind  = fpau_pkg::FPAU_K_BYTE;
							d.op_lo = ext_byte;
						end
						else if (dec_c[0])
						begin
							d.kind  = fpau_pkg::FPAU_K_HALF;
							d.op_lo = ext_half;
						end
						else if (dec_c == `FPAU_C_DOUBLE)
						begin
							d.kind = fpau_pkg::FPAU_K_DOUBLE;
							d.st   = fpau_pkg::FPAU_S_RD_LO;
						end
						else
						begin
							d.kind = fpau_pkg::FPAU_K_WORD;
						end
					end
					else if ((dec_opc == `FPAU_OP_REG_REG)
						&& (dec_aug == `FPAU_AUG_ADD))
					begin
						d.busy = 1'b1;
						d.kind = fpau_pkg::FPAU_K_REGREG;
						d.st   = fpau_pkg::FPAU_S_RD_LO;
					end
					else
					begin
						// not an add this unit performs: condition code kept
						d.illegal = 1'b1;
						d.done    = 1'b1;
					end
				end
			end
			fpau_pkg::FPAU_S_RD_LO:
			begin
				if (!bus_gpr_rd)
				begin
					d.st = fpau_pkg::FPAU_S_CAP_LO;
				end
			end
			fpau_pkg::FPAU_S_CAP_LO:
			begin
				if (q.kind == fpau_pkg::FPAU_K_REGREG)
				begin
					d.op_lo = rf.rd_data;
				end
				else
				begin
					d.sum_lo = lo33[31:0];
					d.carry  = lo33[32];
				end
				d.st = fpau_pkg::FPAU_S_RD_HI;
			end
			fpau_pkg::FPAU_S_RD_HI:
			begin
				if (!bus_gpr_rd)
				begin
					d.st = fpau_pkg::FPAU_S_CAP_HI;
				end
			end
			fpau_pkg::FPAU_S_CAP_HI:
			begin
				d.sum_hi = res;
				d.cc[`FPAU_CC_EXC]  = ovf;
				d.cc[`FPAU_CC_POS]  = !res_neg && !res_zero;
				d.cc[`FPAU_CC_NEG]  = res_neg;
				d.cc[`FPAU_CC_ZERO] = res_zero;
				if (q.kind == fpau_pkg::FPAU_K_DOUBLE)
				begin
					d.st = fpau_pkg::FPAU_S_WR_LO;
				end
				else
				begin
					d.st = fpau_pkg::FPAU_S_WR_HI;
				end
			end
			fpau_pkg::FPAU_S_WR_LO:
			begin
				if (!bus_gpr_wr)
				begin
					d.st = fpau_pkg::FPAU_S_WR_HI;
				end
			end
			fpau_pkg::FPAU_S_WR_HI:
			begin
				if (!bus_gpr_wr)
				begin
					d.busy = 1'b0;
					d.done = 1'b1;
					d.st   = fpau_pkg::FPAU_S_IDLE;
				end
			end
			default:
			begin
				d.st   = fpau_pkg::FPAU_S_IDLE;
				d.busy = 1'b0;
			end
		endcase
		// flags computed from the adder win over a software write of
		// the same cycle, so no result is lost
		if (q.st == fpau_pkg::FPAU_S_CAP_HI)
		begin
			d.cc[`FPAU_CC_EXC] = ovf;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			q    <= '0;
			q.st <= fpau_pkg::FPAU_S_IDLE;
			q.cc <= `FPAU_CC_RESET;
		end
		else if (i_ce)
		begin
			q <= d;
		end
	end

	// register file data is itself a flop; only the select is muxed
	assign o_reg_rdata    = q.rd_gpr ? rf.rd_data : q.misc_rdata;
	assign o_cond_code    = q.cc;
	assign o_busy         = q.busy;
	assign o_done         = q.done;
	assign o_illegal      = q.illegal;
	assign o_operand_addr = q.oper_addr;
	assign o_addr_direct  = q.addr_direct;
endmodule // fpau_top
`default_nettype wire

// ### tb/fpau_mem_model.sv
`default_nettype none
// memory operand side: words picked by instruction address bits 4:2
module fpau_mem_model (
	input  wire logic [31:0] i_instr,
	output logic      [31:0] o_hi,
	output logic      [31:0] o_lo
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [0:7];
	logic [2:0]  w;
	assign w = i_instr[4:2];
	// even word is the high half of a doubleword
	assign o_hi = mem[{w[2:1], 1'b0}];
	// byte or halfword is moved down to the low end; upper bits stay
	// as found so the unit must discard them itself
	always_comb
	begin
		if (i_instr[19])
		begin
			o_lo = mem[w] >> {~i_instr[1:0], 3'h0};
		end
		else if (i_instr[0])
		begin
			o_lo = mem[w] >> {~i_instr[1], 4'h0};
		end
		else if (i_instr[1])
		begin
			o_lo = mem[{w[2:1], 1'b1}];
		end
		else
		begin
			o_lo = mem[w];
		end
	end
endmodule // fpau_mem_model
`default_nettype wire

// ### tb/fpau_top_properties.sv
`default_nettype none
`include "fpau_defs.svh"
module fpau_top_properties (
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	input wire logic        i_ce,
	input wire logic        i_start,
	input wire logic        i_reg_wr,
	input wire logic [31:0] i_instr,
	input wire logic [3:0]  o_cond_code,
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic        o_illegal,
	input wire logic [19:0] o_operand_addr,
	input wire logic        o_addr_direct
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic [5:0] opc = i_instr[31:26];
	wire logic [19:0] addr_f = i_instr[19:0];
	wire logic [2:0] xi_f = i_instr[22:20];
	wire logic legal = (opc == `FPAU_OP_ADD_MEM) ||
		(opc == `FPAU_OP_REG_REG && i_instr[19:16] == `FPAU_AUG_ADD);
	sequence s_take;
		i_ce && i_start && !o_busy;
	endsequence
	sequence s_good;
		s_take ##0 legal;
	endsequence
	sequence s_bad;
		s_take ##0 (!legal && !i_reg_wr);
	endsequence
	sequence s_end;
		o_done && !o_illegal;
	endsequence
	property p_run;
		s_good |=> o_busy ##[2:20] (o_done && !o_busy);
	endproperty
	property p_refuse;
		s_bad |=> o_done && o_illegal && $stable(o_cond_code);
	endproperty
	property p_addr;
		s_good |=> o_operand_addr == $past(addr_f) &&
			o_addr_direct == ($past(xi_f) == 3'h0);
	endproperty
	property p_hold;
		!i_ce |=> $stable(o_cond_code) && $stable(o_busy) &&
			$stable(o_done) && $stable(o_illegal);
	endproperty
	property p_sign;
		s_end |-> !(o_cond_code[1] && o_cond_code[0]);
	endproperty
	property p_pos;
		s_end |-> o_cond_code[2] == !(o_cond_code[1] || o_cond_code[0]);
	endproperty
	property p_pulse;
		o_done |=> !o_done;
	endproperty
	property p_busy;
		$fell(o_busy) |-> o_done;
	endproperty
	property p_ill;
		o_illegal && !(i_start && i_ce) |=> o_illegal;
	endproperty
	a_run: assert property (p_run) else $error("add never done");
	a_refuse: assert property (p_refuse) else $error("bad refusal");
	a_addr: assert property (p_addr) else $error("address wrong");
	a_sign: assert property (p_sign) else $error("neg and zero");
	a_pos: assert property (p_pos) else $error("positive wrong");
	a_pulse: assert property (p_pulse) else $error("done too long");
	a_busy: assert property (p_busy) else $error("busy fell alone");
	a_ill: assert property (p_ill) else $error("illegal lost");
	a_hold: assert property (p_hold) else $error("state moved");
endmodule // fpau_top_properties
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
`include "fpau_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, ce = 1, start = 0, wr = 0, rd = 0;
	logic [31:0] instr = 0, wdata = 0, rdata, op_hi, op_lo, got;
	logic [7:0]  addr = 0;
	logic [3:0]  cc;
	logic [19:0] oaddr;
	logic        busy, done, ill, dir;
	int          bad_count = 0, tests_run = 0;
	always #20 clk = ~clk;
	fpau_mem_model mem_u (.i_instr(instr), .o_hi(op_hi), .o_lo(op_lo));
	fpau_top DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_start(start), .i_instr(instr), .i_operand_hi(op_hi),
		.i_operand_lo(op_lo), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_cond_code(cc), .o_busy(busy), .o_done(done), .o_illegal(ill),
		.o_operand_addr(oaddr), .o_addr_direct(dir));
	task automatic finish_test();
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [2:0] r, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= {3'h0, r, 2'h0};
		wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 got = rdata;
	endtask
	// start, then wait up to 20 cycles for done; operands follow from instr via the model
	task automatic run(input logic [31:0] ins);
		int n;
		@(posedge clk);
		start <= 1;
		instr <= ins;
		@(posedge clk);
		start <= 0;
		#1;
		for (n = 0; n < 20 && done !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1)
		begin
			bad_count++;
			$display("ERROR t=%0t done=%h exp=%h", $time, done, 1'b1);
			finish_test();
		end
	endtask
	function automatic logic [31:0] mi(logic [2:0] r, logic [1:0] c,
		logic f, logic [2:0] w);
		return {`FPAU_OP_ADD_MEM, r, 3'h0, f, 14'h0, w, c};
	endfunction
	task automatic t_rst();
		rreg(8'h20);
		chk(got, 32'h0);
		rreg(8'h1c);
		chk(got, 32'h0);
		rreg(8'h40);
		chk(got, 32'h0);
		$display("reset test done");
	endtask
	// a write while the enable is low must leave no trace
	task automatic t_ce();
		@(posedge clk);
		ce <= 0;
		wr <= 1;
		addr <= 8'h20;
		wdata <= 32'hf;
		@(posedge clk);
		ce <= 1;
		wr <= 0;
		rreg(8'h20);
		chk(got, 32'h0);
		chk({28'h0, cc}, 32'h0);
		$display("enable test done");
	endtask
	task automatic t_mem(input logic [2:0] r, input logic [1:0] c,
		input logic f, input logic [31:0] g, m, e, input logic [3:0] ec);
		logic [31:0] ins;
		ins = mi(r, c, f, 3'h3);
		mem_u.mem[3] = m;
		wreg(r, g);
		run(ins);
		chk({12'h0, oaddr}, {12'h0, ins[19:0]});
		chk({31'h0, dir}, 32'h1);
		rreg({3'h0, r, 2'h0});
		chk(got, e);
		rreg(8'h20);
		chk(got, {28'h0, ec});
		$display("memory add test done");
	endtask
	task automatic t_dbl(input logic [2:0] r, input logic [31:0] gh, gl,
		mh, ml, eh, el, input logic [3:0] ec);
		mem_u.mem[2] = mh;
		mem_u.mem[3] = ml;
		wreg(r, gh);
		wreg(r + 3'h1, gl);
		run(mi(r, 2'h2, 1'b0, 3'h2));
		rreg({3'h0, r, 2'h0});
		chk(got, eh);
		rreg({3'h0, r + 3'h1, 2'h0});
		chk(got, el);
		chk({28'h0, cc}, {28'h0, ec});
		$display("doubleword test done");
	endtask
	task automatic t_rr();
		wreg(3'h6, 32'hff03c67d);
		wreg(3'h7, 32'h045c6e3f);
		run({`FPAU_OP_REG_REG, 3'h6, 3'h7, 4'h0, 16'h0});
		rreg(8'h18);
		chk(got, 32'h036034bc);
		rreg(8'h1c);
		chk(got, 32'h045c6e3f);
		chk({28'h0, cc}, 32'h4);
		$display("register add test done");
	endtask
	// refused codes must leave a software-written condition code alone
	task automatic t_ill();
		wreg(3'h0, 32'h0);
		@(posedge clk);
		wr <= 1;
		addr <= 8'h20;
		wdata <= 32'h9;
		@(posedge clk);
		wr <= 0;
		run({6'h3f, 26'h0});
		chk({31'h0, ill}, 32'h1);
		run({`FPAU_OP_REG_REG, 3'h1, 3'h2, 4'h1, 16'h0});
		chk({31'h0, ill}, 32'h1);
		chk({31'h0, dir}, 32'h0);
		chk({28'h0, cc}, 32'h9);
		$display("refusal test done");
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		t_rst();
		t_ce();
		t_mem(3'h4, 2'h3, 1'b1, 32'h99, 32'hffffff8a, 32'h123, 4'h4);
		t_mem(3'h7, 2'h3, 1'b0, 32'h6c4, 32'h12348c42, 32'hffff9306,
			4'h2);
		t_mem(3'h6, 2'h0, 1'b0, 32'h0037c1f3, 32'h004fc276,
			32'h00878469, 4'h4);
		t_mem(3'h1, 2'h0, 1'b0, 32'h7fffffff, 32'h1, 32'h80000000,
			4'ha);
		t_mem(3'h2, 2'h0, 1'b0, 32'hffffffff, 32'h1, 32'h0, 4'h1);
		t_dbl(3'h4, 32'h000298a1, 32'h815bc63e, 32'h3b69a07e,
			32'h7f3579a4, 32'h3b6c3920, 32'h00913fe2, 4'h4);
		t_dbl(3'h7, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 4'h4);
		t_dbl(3'h2, 32'h7fffffff, 32'hffffffff, 32'h0, 32'h1,
			32'h80000000, 32'h0, 4'ha);
		t_rr();
		t_ill();
		finish_test();
	end
endmodule // tb_top
bind fpau_top fpau_top_properties u_props (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_ce(i_ce), .i_start(i_start),
	.i_reg_wr(i_reg_wr), .i_instr(i_instr), .o_cond_code(o_cond_code),
	.o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal),
	.o_operand_addr(o_operand_addr), .o_addr_direct(o_addr_direct));
`default_nettype wire
